// file: core/exec_pkg.sv
package exec_pkg;
  // Instruction word layout
  localparam int unsigned WORD_W = 12;
  localparam int unsigned PC_W = 9;
  localparam int unsigned FILE_COUNT = 32;
  localparam int unsigned STACK_DEPTH = 2;
  // Timing: one short cycle, two when the counter is disturbed
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SHORT_NS = 1000;
  localparam int unsigned LONG_NS = 2000;
  localparam int unsigned SHORT_CYC = SHORT_NS * CLK_MHZ / 1000;
  localparam int unsigned LONG_CYC = LONG_NS * CLK_MHZ / 1000;
  // Reset values
  localparam logic [8:0] PC_RESET = 9'h1ff;
  localparam logic [7:0] W_RESET = 8'h00;
  // Special file addresses
  localparam logic [4:0] F_INDIRECT = 5'h00;
  localparam logic [4:0] F_TIMER = 5'h01;
  localparam logic [4:0] F_COUNTER = 5'h02;
  localparam logic [4:0] F_STATUS = 5'h03;
  localparam logic [4:0] F_INDEX = 5'h04;
  // Status bit positions
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z = 2;
  // Top-level groups, word[11:10]
  localparam logic [1:0] GRP_FILE0 = 2'h0;
  localparam logic [1:0] GRP_FILE1 = 2'h1;
  localparam logic [1:0] GRP_BIT = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;
  // Bit group: word[9:8]
  localparam logic [1:0] BIT_CLR = 2'h0;
  localparam logic [1:0] BIT_SET = 2'h1;
  localparam logic [1:0] BIT_TSC = 2'h2;
  localparam logic [1:0] BIT_TSS = 2'h3;
  // Literal group: word[10:8] with word[11]=1, word[10]=1 -> 3 bits 2:0 of op
  typedef enum logic [2:0] {
    LIT_LOAD = 3'b000,
    LIT_AND = 3'b001,
    LIT_OR = 3'b010,
    LIT_XOR = 3'b011,
    LIT_RET = 3'b100,
    LIT_CALL = 3'b101,
    LIT_JUMP = 3'b110,
    LIT_NOP = 3'b111
  } lit_op_t;
  // File group: word[9:6]
  typedef enum logic [3:0] {
    FOP_AND = 4'h0,
    FOP_OR = 4'h1,
    FOP_XOR = 4'h2,
    FOP_ADD = 4'h3,
    FOP_MOVW = 4'h4,
    FOP_INC = 4'h5,
    FOP_COM = 4'h6,
    FOP_MOVF = 4'h7,
    FOP_SUB = 4'h8,
    FOP_DECSZ = 4'h9,
    FOP_RR = 4'ha,
    FOP_RL = 4'hb,
    FOP_SWAP = 4'hc,
    FOP_INCSZ = 4'hd,
    FOP_CLR = 4'he,
    FOP_DEC = 4'hf
  } file_op_t;
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10
  } exec_state_t;
endpackage

// file: core/exec_alu.sv
`timescale 1ns/1ps
module exec_alu (
  input wire logic [3:0] op_i,
  input wire logic [7:0] f_i,
  input wire logic [7:0] w_i,
  input wire logic c_i,
  output logic [7:0] res_o,
  output logic c_o,
  output logic dc_o,
  output logic z_o,
  output logic upd_c_o,
  output logic upd_dc_o,
  output logic upd_z_o
);
  wire logic [7:0] b_opnd;
  wire logic cin;
  wire logic [4:0] low_sum;
  wire logic [8:0] full_sum;
  wire logic arith;

  // Subtract is f + ~w + 1 on the same adder
  assign arith = (op_i == exec_pkg::FOP_ADD) || (op_i == exec_pkg::FOP_SUB);
  assign b_opnd = (op_i == exec_pkg::FOP_SUB) ? ~w_i : w_i;
  assign cin = (op_i == exec_pkg::FOP_SUB);
  assign low_sum = {1'b0, f_i[3:0]} + {1'b0, b_opnd[3:0]} + {4'h0, cin}; // [RULE_15]
  assign full_sum = {1'b0, f_i} + {1'b0, b_opnd} + {8'h00, cin};

  always_comb begin
    res_o = 8'h00;
    c_o = c_i;
    upd_c_o = 1'b0;
    upd_z_o = 1'b1; // [RULE_12]
    case (op_i)
      exec_pkg::FOP_AND: res_o = w_i & f_i;
      exec_pkg::FOP_OR: res_o = w_i | f_i;
      exec_pkg::FOP_XOR: res_o = w_i ^ f_i;
      exec_pkg::FOP_ADD, exec_pkg::FOP_SUB: begin
        res_o = full_sum[7:0];
        c_o = full_sum[8];
        upd_c_o = 1'b1; // [RULE_12]
      end
      exec_pkg::FOP_MOVW: begin
        res_o = w_i;
        upd_z_o = 1'b0;
      end
      exec_pkg::FOP_INC: res_o = f_i + 8'h01;
      exec_pkg::FOP_COM: res_o = ~f_i;
      exec_pkg::FOP_MOVF: res_o = f_i;
      exec_pkg::FOP_DECSZ: begin
        res_o = f_i - 8'h01; // [RULE_07]
        upd_z_o = 1'b0;
      end
      exec_pkg::FOP_RR: begin
        res_o = {c_i, f_i[7:1]}; // [RULE_09]
        c_o = f_i[0];
        upd_c_o = 1'b1;
        upd_z_o = 1'b0;
      end
      exec_pkg::FOP_RL: begin
        res_o = {f_i[6:0], c_i}; // [RULE_10]
        c_o = f_i[7];
        upd_c_o = 1'b1;
        upd_z_o = 1'b0;
      end
      exec_pkg::FOP_SWAP: begin
        res_o = {f_i[3:0], f_i[7:4]}; // [RULE_11]
        upd_z_o = 1'b0;
      end
      exec_pkg::FOP_INCSZ: begin
        res_o = f_i + 8'h01; // [RULE_08]
        upd_z_o = 1'b0;
      end
      exec_pkg::FOP_CLR: res_o = 8'h00;
      default: res_o = f_i - 8'h01;
    endcase
  end

  assign dc_o = low_sum[4];
  assign upd_dc_o = arith;
  assign z_o = (res_o == 8'h00);
endmodule

// file: core/exec_unit.sv
// How it works
// [RULE_01] A call pushes the counter and jumps to the literal; a return loads W and pops.
// [RULE_02] Bit operations pick one of eight bits with a three-bit field.
// [RULE_03] Bit operations pick one of 32 files; set writes one, clear writes zero.
// [RULE_04] Bit-test-skip adds two to the counter when its test is true, else one.
// [RULE_05] The destination bit sends a file result to W or back to the file.
// [RULE_06] File operations address one of 32 files with a five-bit field.
// [RULE_07] Decrement-skip writes operand minus one and skips when it is zero.
// [RULE_08] Increment-skip writes operand plus one and skips when it is zero.
// [RULE_09] Rotate right goes through carry: bit 0 to carry, carry to bit 7.
// [RULE_10] Rotate left goes through carry: bit 7 to carry, carry to bit 0.
// [RULE_11] Swap exchanges nibbles and leaves all flags alone.
// [RULE_12] Logic, moves, inc, dec, complement and clear touch Z; add and subtract touch C, DC, Z. FOP_MOVW leaves Z unchanged here.
// [RULE_13] Opcode patterns are an encoding of our own inside the given field widths.
// [RULE_14] An instruction takes one short period, two when it skips or changes the counter.
// [RULE_15] Digit carry holds the carry out of the low nibble on add and subtract.
// [RULE_16] File address zero is indirect through the low five bits of the index register.
`timescale 1ns/1ps
module exec_unit #(
  parameter int unsigned SHORT_CYCLES = exec_pkg::SHORT_CYC,
  parameter int unsigned LONG_CYCLES = exec_pkg::LONG_CYC
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Program memory, combinational read
  output logic [8:0] instr_addr_o,
  input wire logic [11:0] instr_data_i,
  // Software register port
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Observed state
  output logic [7:0] working_reg_o,
  output logic [2:0] status_flags_o,
  output logic [8:0] return_stack_top_o,
  output logic instr_done_o,
  output logic skip_taken_o
);
  // Fetch, execute and one wait need three cycles at least
  if (SHORT_CYCLES < 3 || LONG_CYCLES <= SHORT_CYCLES || LONG_CYCLES > 16'hffff) begin : g_bad_cyc
    $error("exec_unit: cycle counts unusable");
  end

  // ----------------------------------------
  // Architectural state
  // ----------------------------------------
  logic [7:0] file_mem [exec_pkg::FILE_COUNT];
  logic [8:0] instruction_counter;
  logic [8:0] return_stack [exec_pkg::STACK_DEPTH];
  logic [7:0] working_reg;
  logic carry_flag;
  logic digit_carry_flag;
  logic zero_flag;
  logic [4:0] index_select_register;
  logic [11:0] ir;
  exec_pkg::exec_state_t state;
  logic [15:0] cyc_cnt;
  logic long_instr;
  logic [7:0] rdata;
  logic done_q;
  logic skip_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic [1:0] grp = ir[11:10];
  wire logic is_bit = (grp == exec_pkg::GRP_BIT);
  wire logic is_lit = (grp == exec_pkg::GRP_LIT);
  wire logic is_file = !is_bit && !is_lit;
  wire logic [1:0] bit_op = ir[9:8];
  wire logic [2:0] bit_sel = ir[7:5]; // [RULE_02]
  wire logic [3:0] fop = ir[9:6]; // [RULE_13]
  wire logic dest_file = ir[5]; // [RULE_05]
  // Literal group: word[9] picks the control half, word[8] the sub-operation
  wire logic [7:0] literal = ir[7:0];
  // Only load and and fit in the data half beside an 8-bit literal;
  // a plain jump is a file write to the counter.
  wire logic [4:0] raw_addr = ir[4:0]; // [RULE_03] [RULE_06]
  wire logic [4:0] eff_addr = (raw_addr == exec_pkg::F_INDIRECT) ?
                              index_select_register : raw_addr; // [RULE_16]

  // Control half of the literal group disturbs the counter
  // and so always takes the long period
  wire logic lit_ctl = is_lit && ir[9];

  // ----------------------------------------
  // File read path
  // ----------------------------------------
  wire logic [7:0] status_byte = {5'h1f, zero_flag, digit_carry_flag, carry_flag};
  function automatic logic [7:0] file_read(input logic [4:0] a, input logic [7:0] sb,
                                           input logic [8:0] pc, input logic [4:0] idx,
                                           input logic [7:0] mem_val);
    logic [7:0] v;
    v = mem_val;
    if (a == exec_pkg::F_TIMER) begin
      v = 8'hff;
    end else if (a == exec_pkg::F_COUNTER) begin
      v = pc[7:0];
    end else if (a == exec_pkg::F_STATUS) begin
      v = sb;
    end else if (a == exec_pkg::F_INDEX) begin
      v = {3'h7, idx};
    end else if (a == exec_pkg::F_INDIRECT) begin
      v = 8'h00;
    end
    return v;
  endfunction

  wire logic [7:0] f_val = file_read(eff_addr, status_byte, instruction_counter,
                                      index_select_register, file_mem[eff_addr]);

  // ----------------------------------------
  // ALU
  // ----------------------------------------
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic upd_c;
  logic upd_dc;
  logic upd_z;

  exec_alu u_alu (
    .op_i(fop),
    .f_i(f_val),
    .w_i(working_reg),
    .c_i(carry_flag),
    .res_o(alu_res),
    .c_o(alu_c),
    .dc_o(alu_dc),
    .z_o(alu_z),
    .upd_c_o(upd_c),
    .upd_dc_o(upd_dc),
    .upd_z_o(upd_z)
  );

  // ----------------------------------------
  // Next-state computation for one instruction
  // ----------------------------------------
  wire logic [7:0] bit_mask = 8'h01 << bit_sel;
  wire logic bit_val = f_val[bit_sel];
  wire logic bit_skip = (bit_op == exec_pkg::BIT_TSS && bit_val) ||
                        (bit_op == exec_pkg::BIT_TSC && !bit_val); // [RULE_04]
  wire logic cnt_skip = (fop == exec_pkg::FOP_DECSZ || fop == exec_pkg::FOP_INCSZ) &&
                        (alu_res == 8'h00); // [RULE_07] [RULE_08]
  wire logic do_skip = (is_bit && bit_skip) || (is_file && cnt_skip);
  wire logic pc_load = lit_ctl || (is_file && dest_file && eff_addr == exec_pkg::F_COUNTER);
  wire logic [8:0] pc_plus1 = instruction_counter + 9'h001;
  wire logic [8:0] pc_plus2 = instruction_counter + 9'h002; // [RULE_04]

  logic [7:0] next_w;
  logic next_file_we;
  logic [7:0] next_file_val;
  logic [8:0] next_pc;
  logic next_push;
  logic next_pop;
  logic next_c;
  logic next_dc;
  logic next_z;

  always_comb begin
    next_w = working_reg;
    next_file_we = 1'b0;
    next_file_val = alu_res;
    next_pc = do_skip ? pc_plus2 : pc_plus1;
    next_push = 1'b0;
    next_pop = 1'b0;
    next_c = carry_flag;
    next_dc = digit_carry_flag;
    next_z = zero_flag;
    if (is_bit) begin
      if (bit_op == exec_pkg::BIT_SET) begin
        next_file_we = 1'b1;
        next_file_val = f_val | bit_mask; // [RULE_03]
      end else if (bit_op == exec_pkg::BIT_CLR) begin
        next_file_we = 1'b1;
        next_file_val = f_val & ~bit_mask; // [RULE_03]
      end
    end else if (is_file) begin
      if (dest_file) begin
        next_file_we = 1'b1; // [RULE_05]
      end else begin
        next_w = alu_res;
      end
      if (upd_c) begin
        next_c = alu_c;
      end
      if (upd_dc) begin
        next_dc = alu_dc; // [RULE_15]
      end
      if (upd_z) begin
        next_z = alu_z;
      end
    end else if (!lit_ctl) begin
      case (ir[9:8])
        2'h0: next_w = literal;
        2'h1: begin
          next_w = literal & working_reg;
          next_z = ((literal & working_reg) == 8'h00);
        end
        2'h2: begin
          next_w = literal | working_reg;
          next_z = ((literal | working_reg) == 8'h00);
        end
        default: begin
          next_w = literal ^ working_reg;
          next_z = ((literal ^ working_reg) == 8'h00);
        end
      endcase
    end else begin
      case (ir[9:8])
        2'h2: begin
          next_w = literal; // [RULE_01]
          next_pc = return_stack[0];
          next_pop = 1'b1;
        end
        2'h3: begin
          // Return address is the word after the call;
          // the push below stores it, the literal is the target
          // within the lower half of program space
          next_pc = {1'b0, literal};
          next_push = 1'b1; // [RULE_01]
        end
        default: next_pc = {1'b0, literal};
      endcase
    end
    // A file write to the counter redirects the flow
    if (is_file && dest_file && eff_addr == exec_pkg::F_COUNTER) begin
      next_pc = {1'b0, alu_res};
    end
  end

  // Literal group split: word[9]=1 control, word[9]=0 data -- grp 3 only
  // Sub-ops above: word[9]=1 selects control (return, call)

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  wire logic long_now = do_skip || pc_load; // [RULE_14]
  wire logic [15:0] target = long_instr ? 16'(LONG_CYCLES) : 16'(SHORT_CYCLES);
  wire logic sw_wr = reg_wr_i && (state != exec_pkg::ST_EXEC);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= exec_pkg::ST_FETCH;
      cyc_cnt <= 16'h0000;
      long_instr <= 1'b0;
      ir <= 12'h000;
    end else begin
      case (state)
        exec_pkg::ST_FETCH: begin
          ir <= instr_data_i;
          cyc_cnt <= 16'h0001;
          state <= exec_pkg::ST_EXEC;
        end
        exec_pkg::ST_EXEC: begin
          long_instr <= long_now;
          cyc_cnt <= cyc_cnt + 16'h0001;
          state <= exec_pkg::ST_WAIT;
        end
        default: begin
          if (cyc_cnt + 16'h0001 >= target) begin // [RULE_14]
            state <= exec_pkg::ST_FETCH;
          end
          cyc_cnt <= cyc_cnt + 16'h0001;
        end
      endcase
    end
  end

  wire logic exec_now = (state == exec_pkg::ST_EXEC);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      instruction_counter <= exec_pkg::PC_RESET;
      working_reg <= exec_pkg::W_RESET;
      carry_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      index_select_register <= 5'h00;
      return_stack[0] <= 9'h000;
      return_stack[1] <= 9'h000;
      done_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      done_q <= exec_now;
      skip_q <= exec_now && do_skip;
      if (exec_now) begin
        instruction_counter <= next_pc;
        working_reg <= next_w;
        carry_flag <= next_c;
        digit_carry_flag <= next_dc;
        zero_flag <= next_z;
        if (next_push) begin
          return_stack[0] <= pc_plus1; // [RULE_01]
          return_stack[1] <= return_stack[0];
        end else if (next_pop) begin
          return_stack[0] <= return_stack[1]; // [RULE_01]
        end
        if (next_file_we && eff_addr == exec_pkg::F_STATUS) begin
          carry_flag <= next_file_val[exec_pkg::ST_C];
          digit_carry_flag <= next_file_val[exec_pkg::ST_DC];
          zero_flag <= next_file_val[exec_pkg::ST_Z];
        end
        if (next_file_we && eff_addr == exec_pkg::F_INDEX) begin
          index_select_register <= next_file_val[4:0];
        end
      end else if (sw_wr && reg_addr_i == exec_pkg::F_INDEX) begin
        index_select_register <= reg_wdata_i[4:0];
      end
    end
  end

  // General file storage, no reset so it maps to RAM
  always_ff @(posedge core_clk_i) begin
    if (exec_now && next_file_we && eff_addr > exec_pkg::F_INDEX) begin
      file_mem[eff_addr] <= next_file_val;
    end else if (sw_wr && reg_addr_i > exec_pkg::F_INDEX) begin
      file_mem[reg_addr_i] <= reg_wdata_i;
    end
  end

  // ----------------------------------------
  // Software read port
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata <= 8'h00;
    end else if (reg_rd_i) begin
      rdata <= file_read(reg_addr_i, status_byte, instruction_counter,
                         index_select_register, file_mem[reg_addr_i]);
    end
  end

  assign reg_rdata_o = rdata;
  assign instr_addr_o = instruction_counter;
  assign working_reg_o = working_reg;
  assign status_flags_o = {zero_flag, digit_carry_flag, carry_flag};
  assign return_stack_top_o = return_stack[0];
  assign instr_done_o = done_q;
  assign skip_taken_o = skip_q;
endmodule

// file: bench/exec_unit_chk.sv
`timescale 1ns/1ps
module exec_unit_chk #(
  parameter int unsigned SHORT_CYCLES = 100,
  parameter int unsigned LONG_CYCLES = 200
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [8:0] instr_addr_o,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] working_reg_o,
  input wire logic [2:0] status_flags_o,
  input wire logic [8:0] return_stack_top_o,
  input wire logic instr_done_o,
  input wire logic skip_taken_o
);
  // ----------------------------------------
  // History of the last two completions
  // ----------------------------------------
  logic [9:0] gap;
  logic [1:0] seen;
  logic [8:0] pc1;
  logic [8:0] pc2;
  logic skip1;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap <= 10'h000;
      seen <= 2'h0;
      pc1 <= 9'h000;
      pc2 <= 9'h000;
      skip1 <= 1'b0;
    end else if (instr_done_o) begin
      gap <= 10'h001;
      seen <= (seen == 2'h3) ? seen : seen + 2'h1;
      pc1 <= instr_addr_o;
      pc2 <= pc1;
      skip1 <= skip_taken_o;
    end else begin
      gap <= gap + 10'h001;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  skip_done_a: assert property (skip_taken_o |-> instr_done_o)
    else $error("skip pulse without completion");
  done_pulse_a: assert property (instr_done_o |=> !instr_done_o)
    else $error("completion pulse longer than one cycle");
  period_len_a: assert property (instr_done_o && seen != 2'h0 |->
    gap == SHORT_CYCLES || gap == LONG_CYCLES)
    else $error("instruction period neither short nor long");
  skip_long_a: assert property (instr_done_o && seen != 2'h0 && skip1 |->
    gap == LONG_CYCLES)
    else $error("skipping instruction not given the long period");
  skip_step_a: assert property (instr_done_o && seen != 2'h0 && skip_taken_o |->
    instr_addr_o == pc1 + 9'h002)
    else $error("skip did not advance the counter by two");
  short_step_a: assert property (instr_done_o && seen[1] && gap == SHORT_CYCLES |->
    pc1 == pc2 + 9'h001)
    else $error("short instruction moved the counter by other than one");
  state_hold_a: assert property (!$stable(working_reg_o) || !$stable(status_flags_o) ||
    !$stable(return_stack_top_o) |-> instr_done_o)
    else $error("state changed outside an execute cycle");
  index_read_a: assert property (reg_rd_i && reg_addr_i == exec_pkg::F_INDEX |=>
    reg_rdata_o[7:5] == 3'b111)
    else $error("index register upper bits not read as ones");
  status_read_a: assert property (reg_rd_i && reg_addr_i == exec_pkg::F_STATUS |=>
    reg_rdata_o[2:0] == $past(status_flags_o))
    else $error("status read does not match flags");
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module testbench;
  localparam int unsigned SHORT = 4;
  localparam int unsigned LONG = 8;
  // Idle filler: sets a bit of file 31, which no test uses
  localparam logic [11:0] NOP = 12'h9ff;
  // {op, w, f, result, {z, dc, c}}
  localparam logic [30:0] ARITH [0:4] = '{{4'h3, 8'h3a, 8'hc9, 8'h03, 3'b011},
    {4'h8, 8'h10, 8'h10, 8'h00, 3'b111}, {4'h8, 8'h10, 8'h05, 8'hf5, 3'b010},
    {4'h3, 8'h00, 8'h00, 8'h00, 3'b100}, {4'h3, 8'h08, 8'h08, 8'h10, 3'b010}};
  // {op, f, result} with w = 0f
  localparam logic [19:0] LOGIC [0:11] = '{{4'h0, 8'hf0, 8'h00}, {4'h1, 8'hf0, 8'hff},
    {4'h2, 8'hff, 8'hf0}, {4'h5, 8'hff, 8'h00}, {4'h6, 8'hf0, 8'h0f}, {4'h7, 8'h00, 8'h00},
    {4'he, 8'h5a, 8'h00}, {4'hf, 8'h00, 8'hff}, {4'hd, 8'hff, 8'h00}, {4'hd, 8'h10, 8'h11},
    {4'h9, 8'h01, 8'h00}, {4'h9, 8'h02, 8'h01}};
  logic core_clk_i = 1'b0;
  logic rstn_i;
  logic [11:0] instr_data_i;
  logic [4:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  wire logic [8:0] instr_addr_o;
  wire logic [7:0] reg_rdata_o;
  wire logic [7:0] working_reg_o;
  wire logic [2:0] status_flags_o;
  wire logic [8:0] return_stack_top_o;
  wire logic instr_done_o;
  wire logic skip_taken_o;
  int fail_count = 0;
  int n_checks = 0;
  int per;
  logic [8:0] pc0;
  logic [8:0] pc1;
  logic [8:0] ret_pc;
  logic sk;
  logic sk0;
  logic [2:0] fl0;
  logic [7:0] rv;
  logic [30:0] e;
  logic [19:0] e2;
  always #5 core_clk_i = ~core_clk_i;
  exec_unit #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) i_dut (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .instr_addr_o(instr_addr_o),
    .instr_data_i(instr_data_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .working_reg_o(working_reg_o),
    .status_flags_o(status_flags_o),
    .return_stack_top_o(return_stack_top_o),
    .instr_done_o(instr_done_o),
    .skip_taken_o(skip_taken_o)
  );
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (instr_done_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      fail_count++;
      $display("Error instr_done_o expected 1 seen 0");
      print_verdict();
    end
  endtask
  // Writes in an execute cycle are dropped, so strobe just after a completion
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int n;
    wait_done(n);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge core_clk_i);
    d = reg_rdata_o;
  endtask
  // Offers one word between filler words, then measures its period
  task automatic ex(input logic [11:0] w);
    wait_done(per);
    instr_data_i <= w;
    pc0 = instr_addr_o;
    fl0 = status_flags_o;
    wait_done(per);
    instr_data_i <= NOP;
    pc1 = instr_addr_o;
    sk = skip_taken_o;
    wait_done(per);
  endtask
  task automatic step(input int st, input int p, input logic s);
    `CHK("counter", pc0 + 9'(st), pc1)
    `CHK("period", p, per)
    `CHK("skip", s, sk)
  endtask
  function automatic logic [11:0] fw(input logic [3:0] op, input logic d, input logic [4:0] f);
    return {2'b00, op, d, f};
  endfunction
  function automatic logic [11:0] bw(input logic [1:0] k, input int b, input int f);
    return {2'b10, k, 3'(b), 5'(f)};
  endfunction
  task automatic setw(input logic [7:0] v);
    wr(5'h08, v);
    ex(fw(exec_pkg::FOP_MOVF, 1'b0, 5'h08));
  endtask
  task automatic setc(input logic c);
    wr(5'h09, {7'h00, c});
    ex(fw(exec_pkg::FOP_RR, 1'b1, 5'h09));
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rstn_i = 1'b0;
    instr_data_i = NOP;
    reg_addr_i = 5'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      e = ARITH[i];
      setw(e[26:19]);
      wr(5'h0a, e[18:11]);
      ex(fw(e[30:27], 1'b0, 5'h0a));
      `CHK("result", e[10:3], working_reg_o)
      `CHK("flags", e[2:0], status_flags_o)
      rd(5'h0a, rv);
      `CHK("operand file", e[18:11], rv)
    end
    $display("test arith done");
    setc(1'b1);
    setw(8'h0f);
    for (int i = 0; i < 12; i++) begin
      e2 = LOGIC[i];
      wr(5'h0e, e2[15:8]);
      ex(fw(e2[19:16], 1'b1, 5'h0e));
      rd(5'h0e, rv);
      `CHK("file result", e2[7:0], rv)
      if (e2[19:16] == 4'h9 || e2[19:16] == 4'hd) begin
        sk0 = (e2[7:0] == 8'h00);
        step(sk0 ? 2 : 1, sk0 ? LONG : SHORT, sk0);
      end else begin
        `CHK("zero flag", e2[7:0] == 8'h00, status_flags_o[2])
        `CHK("carry flags", fl0[1:0], status_flags_o[1:0])
        step(1, SHORT, 1'b0);
      end
    end
    $display("test file ops done");
    setc(1'b1);
    wr(5'h0b, 8'h02);
    ex(fw(exec_pkg::FOP_RR, 1'b1, 5'h0b));
    rd(5'h0b, rv);
    `CHK("rotate right", 8'h81, rv)
    `CHK("carry", 1'b0, status_flags_o[0])
    wr(5'h0b, 8'h80);
    ex(fw(exec_pkg::FOP_RL, 1'b1, 5'h0b));
    ex(fw(exec_pkg::FOP_RL, 1'b1, 5'h0b));
    rd(5'h0b, rv);
    `CHK("rotate left", 8'h01, rv)
    `CHK("carry", 1'b0, status_flags_o[0])
    setc(1'b1);
    wr(5'h0b, 8'h3c);
    ex(fw(exec_pkg::FOP_SWAP, 1'b0, 5'h0b));
    `CHK("swap", 8'hc3, working_reg_o)
    `CHK("flags", fl0, status_flags_o)
    rd(exec_pkg::F_STATUS, rv);
    `CHK("status read", fl0, rv[2:0])
    ex(12'hc33);
    `CHK("literal load", 8'h33, working_reg_o)
    ex(12'hd0f);
    `CHK("literal and", 8'h03, working_reg_o)
    `CHK("literal and zero", 1'b0, status_flags_o[2])
    $display("test rotate done");
    for (int b = 0; b < 8; b++) begin
      wr(5'(16 + b), 8'h00);
      ex(bw(exec_pkg::BIT_SET, b, 16 + b));
      rd(5'(16 + b), rv);
      `CHK("bit set", 8'h01 << b, rv)
      ex(bw(exec_pkg::BIT_TSS, b, 16 + b));
      step(2, LONG, 1'b1);
      ex(bw(exec_pkg::BIT_TSC, b, 16 + b));
      step(1, SHORT, 1'b0);
      wr(5'(16 + b), 8'hff);
      ex(bw(exec_pkg::BIT_CLR, b, 16 + b));
      rd(5'(16 + b), rv);
      `CHK("bit clear", ~(8'h01 << b), rv)
      ex(bw(exec_pkg::BIT_TSC, b, 16 + b));
      step(2, LONG, 1'b1);
    end
    $display("test bits done");
    wr(exec_pkg::F_INDEX, 8'h0d);
    rd(exec_pkg::F_INDEX, rv);
    `CHK("index", 8'hed, rv)
    wr(5'h0d, 8'h55);
    ex(fw(exec_pkg::FOP_MOVF, 1'b0, 5'h00));
    `CHK("indirect read", 8'h55, working_reg_o)
    ex(fw(exec_pkg::FOP_COM, 1'b1, 5'h00));
    rd(5'h0d, rv);
    `CHK("indirect write", 8'haa, rv)
    $display("test indirect done");
    ex(12'hf40);
    `CHK("call target", 9'h040, pc1)
    `CHK("pushed", pc0 + 9'h001, return_stack_top_o)
    `CHK("period", LONG, per)
    ret_pc = pc0 + 9'h001;
    ex(12'he5a);
    `CHK("return literal", 8'h5a, working_reg_o)
    `CHK("return target", ret_pc, pc1)
    `CHK("period", LONG, per)
    $display("test call done");
    print_verdict();
  end
endmodule
bind exec_unit exec_unit_chk #(.SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)) i_chk (
  .core_clk_i(core_clk_i),
  .rstn_i(rstn_i),
  .instr_addr_o(instr_addr_o),
  .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .working_reg_o(working_reg_o),
  .status_flags_o(status_flags_o),
  .return_stack_top_o(return_stack_top_o),
  .instr_done_o(instr_done_o),
  .skip_taken_o(skip_taken_o)
);
